//--- design/spread_pkg.sv
// Constants shared by the spread-spectrum modulator and its testbench.
// Assumes one core clock and detector rates delivered as enable pulses.
package spread_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OFFSET_OFS = 8'h04;
  localparam logic [7:0] NOMINAL_OFS = 8'h08;
  localparam logic [7:0] SAMPLES_LO_OFS = 8'h0C;
  localparam logic [7:0] SAMPLES_HI_OFS = 8'h10;
  localparam logic [7:0] PLL3_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam int ADDR_W = 8;

  // Field positions.
  localparam int STEP_LSB = 0;
  localparam int STEP_W = 4;
  localparam int QUAD_LSB = 4;
  localparam int QUAD_W = 3;
  localparam int DITHER_BIT = 8;
  localparam int DOUBLE_BIT = 9;
  localparam int PLL3_EN_BIT = 12;
  localparam int OFFSET_W = 6;
  localparam int N_LSB = 0;
  localparam int N_W = 12;
  localparam int A_LSB = 16;
  localparam int A_W = 4;
  localparam int REFDIV_LSB = 0;
  localparam int REFDIV_W = 8;
  localparam int LOOP_LSB = 16;
  localparam int LOOP_W = 16;

  // Profile shape.
  localparam int SAMPLE_COUNT = 12;
  localparam int DELTA_W = 4;
  localparam int IDX_W = 4;
  localparam int ACC_W = 10;
  localparam int PROFILE_W = 12;
  localparam int FRAC_W = 6;
  localparam int M_W = 14;
  localparam int FEEDBACK_W = 21;
  localparam logic [4:0] STEP_EXTRA = 5'h02;
  localparam logic [3:0] QUAD_MULT = 4'h2;

  // Reset values and bus answers.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
endpackage : spread_pkg

//--- design/spread_spectrum_modulator.sv
// Spread-spectrum modulator for two PLLs with an AXI4-Lite register slave.
// Assumes pfdTick, refTick and pll3PfdTick are one-cycle enables on core_clk.
//
// What this block does
// - Holds twelve 4-bit delta samples, uses only the selected count per quadrant.
// - Samples per quadrant equal the quadrant setting times two, capped at twelve.
// - Detector cycles per step equal the step setting plus two.
// - Deltas accumulate onto the offset to form the profile.
// - Dither bit set randomizes the profile LSB; clear leaves it alone.
// - Amplitude-double bit doubles the accumulated delta sum.
// - Second PLL spread runs only while its enable bit is one.
// - Second PLL uses 8-bit reference divide and 16-bit loop counter.
// - Step setting of zero disables first PLL spread.
// - Waveform has four mirrored quadrants built from one sample set.
module spread_spectrum_modulator (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Detector rate enables
  input wire logic pfdTick,
  input wire logic refTick,
  input wire logic pll3PfdTick,
  // Feedback divider of the first PLL
  output logic [spread_pkg::FEEDBACK_W-1:0] feedbackValue,
  output logic spreadActive,
  // Second PLL spread outputs
  output logic [1:0] pll3Phase,
  output logic pll3LoopPulse
);
  typedef struct packed {
    logic [spread_pkg::ADDR_W-1:0] awAddr;
    logic awHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHave;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] ctrl;
    logic [31:0] offset;
    logic [31:0] nominal;
    logic [31:0] samplesLo;
    logic [31:0] samplesHi;
    logic [31:0] pll3;
    logic [4:0] tickCnt;
    logic [spread_pkg::IDX_W-1:0] sampleIdx;
    logic [1:0] quadrant;
    logic signed [spread_pkg::ACC_W-1:0] acc;
    logic [15:0] lfsr;
    logic [spread_pkg::FEEDBACK_W-1:0] feedback;
    logic [1:0] pll3Phase;
  } mod_state_t;

  mod_state_t state_reg;
  mod_state_t state_next;

  logic [3:0] stepSet;
  logic [2:0] quadSet;
  logic spreadOn;
  logic [4:0] stepLast;
  logic [3:0] nSamples;
  logic [spread_pkg::IDX_W-1:0] useIdx;
  logic [47:0] sampleBits;
  logic [spread_pkg::DELTA_W-1:0] delta;
  logic stepNow;
  logic signed [spread_pkg::ACC_W-1:0] accScaled;
  logic signed [spread_pkg::PROFILE_W-1:0] profile;
  logic [spread_pkg::M_W-1:0] mNominal;
  logic [spread_pkg::FEEDBACK_W-1:0] feedbackNext;
  logic [31:0] wMask;
  logic [31:0] readWord;
  logic readHit;
  logic modTick;
  logic ctrlWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings.
  assign stepSet = state_reg.ctrl[spread_pkg::STEP_LSB +: spread_pkg::STEP_W];
  assign quadSet = state_reg.ctrl[spread_pkg::QUAD_LSB +: spread_pkg::QUAD_W];
  assign spreadOn = (stepSet != 4'h0);
  assign stepLast = 5'({1'b0, stepSet} + spread_pkg::STEP_EXTRA - 5'h01);
  assign sampleBits = {state_reg.samplesHi[15:0], state_reg.samplesLo};

  always_comb
  begin
    nSamples = 4'({1'b0, quadSet} * spread_pkg::QUAD_MULT);
    if (nSamples > 4'(spread_pkg::SAMPLE_COUNT))
      nSamples = 4'(spread_pkg::SAMPLE_COUNT);
  end

  assign useIdx = state_reg.quadrant[0] ? (nSamples - 4'h1 - state_reg.sampleIdx)
                                        : state_reg.sampleIdx;
  assign delta = (nSamples == 4'h0) ? 4'h0 : sampleBits[useIdx * 4 +: 4];
  // A control write restarts the profile, so that a smaller step or sample count cannot
  // leave the counters past their new end points or the profile off its centre.
  assign ctrlWrite = state_reg.awHave && state_reg.wHave && !state_reg.bValid
    && (state_reg.awAddr == spread_pkg::CTRL_OFS);
  assign stepNow = spreadOn && pfdTick && !ctrlWrite && (state_reg.tickCnt >= stepLast);

  assign accScaled = state_reg.ctrl[spread_pkg::DOUBLE_BIT] ? (state_reg.acc <<< 1)
                                                            : state_reg.acc;
  assign mNominal = (state_reg.nominal[spread_pkg::A_LSB +: spread_pkg::A_W] == 4'h0)
    ? 14'({state_reg.nominal[spread_pkg::N_LSB +: spread_pkg::N_W], 1'b0})
    : 14'({state_reg.nominal[spread_pkg::N_LSB +: spread_pkg::N_W], 1'b0}
      + 14'(state_reg.nominal[spread_pkg::A_LSB +: spread_pkg::A_W]) + 14'h0001);

  always_comb
  begin
    profile = 12'(state_reg.offset[spread_pkg::OFFSET_W-1:0]) + 12'(accScaled);
    if (state_reg.ctrl[spread_pkg::DITHER_BIT])
      profile[0] = state_reg.lfsr[0];
    if (spreadOn)
      feedbackNext = 21'({mNominal, 6'h00}) + 21'(signed'(profile));
    else
      feedbackNext = 21'({mNominal, 6'h00});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux.
  always_comb
  begin
    readHit = 1'b1;
    case (s_axi_araddr)
      spread_pkg::CTRL_OFS: readWord = state_reg.ctrl;
      spread_pkg::OFFSET_OFS: readWord = state_reg.offset;
      spread_pkg::NOMINAL_OFS: readWord = state_reg.nominal;
      spread_pkg::SAMPLES_LO_OFS: readWord = state_reg.samplesLo;
      spread_pkg::SAMPLES_HI_OFS: readWord = state_reg.samplesHi;
      spread_pkg::PLL3_OFS: readWord = state_reg.pll3;
      spread_pkg::STATUS_OFS: readWord = {8'h00, 3'h0, state_reg.feedback};
      default:
      begin
        readWord = spread_pkg::WORD_ZERO;
        readHit = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wMask[b*8 +: 8] = {8{state_reg.wStrb[b]}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    state_next = state_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      state_next.awAddr = s_axi_awaddr;
      state_next.awHave = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      state_next.wData = s_axi_wdata;
      state_next.wStrb = s_axi_wstrb;
      state_next.wHave = 1'b1;
    end
    if (state_reg.bValid && s_axi_bready)
      state_next.bValid = 1'b0;
    if (state_reg.awHave && state_reg.wHave && !state_reg.bValid)
    begin
      state_next.awHave = 1'b0;
      state_next.wHave = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp = spread_pkg::RESP_OKAY;
      case (state_reg.awAddr)
        spread_pkg::CTRL_OFS:
          state_next.ctrl = (state_reg.ctrl & ~wMask) | (state_reg.wData & wMask);
        spread_pkg::OFFSET_OFS:
          state_next.offset = 32'((state_reg.wData & wMask) | (state_reg.offset & ~wMask))
            & 32'h0000_003F;
        spread_pkg::NOMINAL_OFS:
          state_next.nominal = (state_reg.nominal & ~wMask) | (state_reg.wData & wMask);
        spread_pkg::SAMPLES_LO_OFS:
          state_next.samplesLo = (state_reg.samplesLo & ~wMask) | (state_reg.wData & wMask);
        spread_pkg::SAMPLES_HI_OFS:
          state_next.samplesHi = ((state_reg.samplesHi & ~wMask) | (state_reg.wData & wMask))
            & 32'h0000_FFFF;
        spread_pkg::PLL3_OFS:
          state_next.pll3 = (state_reg.pll3 & ~wMask) | (state_reg.wData & wMask);
        spread_pkg::STATUS_OFS: state_next.bResp = spread_pkg::RESP_OKAY;
        default: state_next.bResp = spread_pkg::RESP_SLVERR;
      endcase
    end
    if (state_reg.rValid && s_axi_rready)
      state_next.rValid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      state_next.rValid = 1'b1;
      state_next.rData = readWord;
      state_next.rResp = readHit ? spread_pkg::RESP_OKAY : spread_pkg::RESP_SLVERR;
    end

    // Modulator stepping; counters and accumulator park at the start point when off or rewritten.
    if (pfdTick)
      state_next.lfsr = {state_reg.lfsr[14:0],
        state_reg.lfsr[15] ^ state_reg.lfsr[13] ^ state_reg.lfsr[12] ^ state_reg.lfsr[10]};
    if (!spreadOn || ctrlWrite)
    begin
      state_next.tickCnt = 5'h00;
      state_next.sampleIdx = '0;
      state_next.quadrant = 2'h0;
      state_next.acc = '0;
    end
    else if (pfdTick)
    begin
      state_next.tickCnt = stepNow ? 5'h00 : state_reg.tickCnt + 5'h01;
      if (stepNow)
      begin
        if (state_reg.quadrant == 2'h0 || state_reg.quadrant == 2'h3)
          state_next.acc = state_reg.acc + 10'(delta);
        else
          state_next.acc = state_reg.acc - 10'(delta);
        if (state_reg.sampleIdx + 4'h1 >= nSamples)
        begin
          state_next.sampleIdx = '0;
          state_next.quadrant = state_reg.quadrant + 2'h1;
        end
        else
        begin
          state_next.sampleIdx = state_reg.sampleIdx + 4'h1;
        end
      end
    end
    if (pfdTick || !spreadOn)
      state_next.feedback = feedbackNext;
    if (!state_reg.ctrl[spread_pkg::PLL3_EN_BIT])
      state_next.pll3Phase = 2'h0;
    else if (modTick)
      state_next.pll3Phase = state_reg.pll3Phase + 2'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_reg <= '0;
      state_reg.ctrl <= spread_pkg::CTRL_RESET;
      state_reg.lfsr <= spread_pkg::LFSR_SEED;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second PLL: quarter-period ticks and loop feedback counter.
  // reference divide
  spread_tick_divider #(.WIDTH(spread_pkg::REFDIV_W)) refDivider (
    .core_clk(core_clk),
    .rstn(rstn),
    .enable(state_reg.ctrl[spread_pkg::PLL3_EN_BIT]),
    .tick(refTick),
    .divide(state_reg.pll3[spread_pkg::REFDIV_LSB +: spread_pkg::REFDIV_W]),
    .pulse(modTick)
  );

  spread_tick_divider #(.WIDTH(spread_pkg::LOOP_W)) loopDivider (
    .core_clk(core_clk),
    .rstn(rstn),
    .enable(state_reg.ctrl[spread_pkg::PLL3_EN_BIT]),
    .tick(pll3PfdTick),
    .divide(state_reg.pll3[spread_pkg::LOOP_LSB +: spread_pkg::LOOP_W]),
    .pulse(pll3LoopPulse)
  );

  assign s_axi_awready = !state_reg.awHave && !state_reg.bValid;
  assign s_axi_wready = !state_reg.wHave && !state_reg.bValid;
  assign s_axi_bvalid = state_reg.bValid;
  assign s_axi_bresp = state_reg.bResp;
  assign s_axi_arready = !state_reg.rValid;
  assign s_axi_rvalid = state_reg.rValid;
  assign s_axi_rdata = state_reg.rData;
  assign s_axi_rresp = state_reg.rResp;
  assign feedbackValue = state_reg.feedback;
  assign spreadActive = spreadOn;
  assign pll3Phase = state_reg.pll3Phase;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sample_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
    spreadOn && nSamples != 4'h0 |-> state_reg.sampleIdx < nSamples)
    else $error("sample index beyond selected count");

  quad_length_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stepNow && state_reg.sampleIdx == 4'(quadSet * 2) - 4'h1 && quadSet <= 3'h6
    |=> state_reg.quadrant == $past(state_reg.quadrant) + 2'h1)
    else $error("quadrant did not advance after its samples");

  step_spacing_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stepNow |-> state_reg.tickCnt == 5'({1'b0, stepSet} + 5'h01))
    else $error("step taken at wrong detector count");

  delta_accum_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stepNow && state_reg.quadrant == 2'h0 |=> state_reg.acc == $past(state_reg.acc)
      + 10'($past(delta)))
    else $error("rising quadrant did not add its delta");

  dither_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    pfdTick && !state_reg.ctrl[spread_pkg::DITHER_BIT] && spreadOn
    |=> state_reg.feedback == $past(21'({mNominal, 6'h00})
      + 21'(signed'(12'(state_reg.offset[5:0]) + 12'(accScaled)))))
    else $error("feedback altered without dither");

  double_amp_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state_reg.ctrl[spread_pkg::DOUBLE_BIT] |-> accScaled == state_reg.acc * 2)
    else $error("amplitude not doubled");

  spread_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !spreadOn ##1 !spreadOn |-> state_reg.acc == '0
      && state_reg.feedback == $past(21'({mNominal, 6'h00})))
    else $error("spread not idle with zero step setting");

  mirror_fall_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stepNow && state_reg.quadrant == 2'h1 |=> state_reg.acc == $past(state_reg.acc)
      - 10'($past(sampleBits[(nSamples - 4'h1 - state_reg.sampleIdx) * 4 +: 4])))
    else $error("falling quadrant not mirrored");

  pll3_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !state_reg.ctrl[spread_pkg::PLL3_EN_BIT] ##1 !state_reg.ctrl[spread_pkg::PLL3_EN_BIT]
    |-> !modTick && !pll3LoopPulse && pll3Phase == 2'h0)
    else $error("second PLL spread running while disabled");

  feedback_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    spreadOn && !pfdTick ##1 spreadOn |-> $stable(state_reg.feedback))
    else $error("feedback changed between detector ticks");
endmodule : spread_spectrum_modulator

//--- design/spread_tick_divider.sv
// Divides a stream of enable ticks by a programmable count.
// Assumes ticks come from logic on core_clk; divide 0 acts as divide 1.
module spread_tick_divider #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic enable,
  input wire logic tick,
  input wire logic [WIDTH-1:0] divide,
  // Result
  output logic pulse
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic pulse;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;
  logic [WIDTH-1:0] lastCount;

  always_comb
  begin
    state_next = state_reg;
    state_next.pulse = 1'b0;
    lastCount = (divide == '0) ? '0 : divide - WIDTH'(1);
    if (!enable)
    begin
      state_next.count = '0;
    end
    else if (tick)
    begin
      if (state_reg.count >= lastCount)
      begin
        state_next.count = '0;
        state_next.pulse = 1'b1;
      end
      else
      begin
        state_next.count = state_reg.count + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign pulse = state_reg.pulse;

  pulse_cause_a: assert property (@(posedge core_clk) disable iff (!rstn)
    pulse |-> $past(tick) && $past(enable))
    else $error("divider pulsed without an enabled tick");
endmodule : spread_tick_divider

//--- testbench/pfd_partner.sv
// Behavioural detector-rate source standing beside the spread modulator.
// Assumes one core clock; the bench sets the tick periods in core cycles.
module pfd_partner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Tick periods, two cycles or more
  input wire logic [3:0] pfdGap,
  input wire logic [3:0] refGap,
  // Detector rate enables
  output logic pfdTick,
  output logic refTick,
  output logic pll3PfdTick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pfdCnt;
  logic [3:0] refCnt;
  logic [3:0] loopCnt;
  // A gap of two or more keeps every tick a lone one-cycle pulse, as a real detector gives.
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pfdCnt <= 4'h0;
      refCnt <= 4'h0;
      loopCnt <= 4'h0;
      pfdTick <= 1'b0;
      refTick <= 1'b0;
      pll3PfdTick <= 1'b0;
    end
    else
    begin
      pfdCnt <= (pfdCnt >= pfdGap - 4'h1) ? 4'h0 : pfdCnt + 4'h1;
      refCnt <= (refCnt >= refGap - 4'h1) ? 4'h0 : refCnt + 4'h1;
      loopCnt <= (loopCnt >= refGap) ? 4'h0 : loopCnt + 4'h1;
      pfdTick <= (pfdCnt == 4'h0);
      refTick <= (refCnt == 4'h0);
      pll3PfdTick <= (loopCnt == 4'h0);
    end
  end
endmodule : pfd_partner

//--- testbench/test_spread_spectrum_modulator.sv
// Self-checking bench for the spread-spectrum modulator over AXI4-Lite.
// Assumes the detector ticks come from pfd_partner on the same core clock.
module test_spread_spectrum_modulator;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic pfdTick;
  logic refTick;
  logic pll3PfdTick;
  logic [20:0] feedbackValue;
  logic spreadActive;
  logic [1:0] pll3Phase;
  logic pll3LoopPulse;
  logic [3:0] pfdGap;
  logic [3:0] refGap;
  logic [20:0] fbPrev;
  logic [1:0] phPrev;
  int fbTk, fbChg, fbBad, fbGapExp, fbMin, fbMax;
  int phTk, phChg, phBad, phGapExp, lpTk, lpChg, lpBad, lpGapExp;
  int cycles, errCount, nTests;

  always #20 core_clk = ~core_clk;

  spread_spectrum_modulator dut_u (.core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pfdTick(pfdTick),
    .refTick(refTick), .pll3PfdTick(pll3PfdTick), .feedbackValue(feedbackValue),
    .spreadActive(spreadActive), .pll3Phase(pll3Phase), .pll3LoopPulse(pll3LoopPulse));

  pfd_partner partner_u (.core_clk(core_clk), .rstn(rstn), .pfdGap(pfdGap), .refGap(refGap),
    .pfdTick(pfdTick), .refTick(refTick), .pll3PfdTick(pll3PfdTick));

  ////////////////////////////////////////////////////////////////////////////////
  // Output monitor: counts ticks between output steps and tracks the profile range.
  always @(posedge core_clk)
  begin
    if (feedbackValue !== fbPrev)
    begin
      if (fbChg > 0 && fbTk != fbGapExp)
        fbBad++;
      fbChg++;
      fbTk = 0;
    end
    if (pfdTick)
      fbTk++;
    fbPrev = feedbackValue;
    if (int'(feedbackValue) < fbMin)
      fbMin = int'(feedbackValue);
    if (int'(feedbackValue) > fbMax)
      fbMax = int'(feedbackValue);
    if (pll3Phase !== phPrev)
    begin
      if (phChg > 0 && phTk != phGapExp)
        phBad++;
      phChg++;
      phTk = 0;
    end
    if (refTick)
      phTk++;
    phPrev = pll3Phase;
    if (pll3LoopPulse)
    begin
      if (lpChg > 0 && lpTk != lpGapExp)
        lpBad++;
      lpChg++;
      lpTk = 0;
    end
    if (pll3PfdTick)
      lpTk++;
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
      begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1)
      begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rdata", s_axi_rdata, ed);
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : axi_read

  // Control goes last, so the profile starts only once offset and samples are in place.
  task automatic cfg(input logic [31:0] c, o, n, lo, hi);
    axi_write(spread_pkg::OFFSET_OFS, o, spread_pkg::RESP_OKAY);
    axi_write(spread_pkg::NOMINAL_OFS, n, spread_pkg::RESP_OKAY);
    axi_write(spread_pkg::SAMPLES_LO_OFS, lo, spread_pkg::RESP_OKAY);
    axi_write(spread_pkg::SAMPLES_HI_OFS, hi, spread_pkg::RESP_OKAY);
    axi_write(spread_pkg::CTRL_OFS, c, spread_pkg::RESP_OKAY);
  endtask : cfg

  // Statistics are cleared on the falling edge so the monitor never races the clear.
  task automatic run(input int n);
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    fbChg = 0;
    fbBad = 0;
    fbMin = 32'h7FFF_FFFF;
    fbMax = 0;
    phChg = 0;
    phBad = 0;
    lpChg = 0;
    lpBad = 0;
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    pfdGap = 4'h2;
    refGap = 4'h2;
    {fbTk, fbGapExp, phTk, phGapExp, lpTk, lpGapExp, cycles, errCount, nTests} = '0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++)
      axi_read(8'(i * 4), spread_pkg::WORD_ZERO, spread_pkg::RESP_OKAY);
    axi_read(8'h1C, spread_pkg::WORD_ZERO, spread_pkg::RESP_SLVERR);
    axi_write(8'h1C, 32'hFFFF_FFFF, spread_pkg::RESP_SLVERR);
    axi_write(spread_pkg::STATUS_OFS, 32'h0000_1234, spread_pkg::RESP_OKAY);
    axi_read(spread_pkg::STATUS_OFS, spread_pkg::WORD_ZERO, spread_pkg::RESP_OKAY);
    axi_write(spread_pkg::PLL3_OFS, 32'h0005_0004, spread_pkg::RESP_OKAY);
    axi_read(spread_pkg::PLL3_OFS, 32'h0005_0004, spread_pkg::RESP_OKAY);
    $display("test registers done");
    // spread off, A zero then nonzero.
    cfg(32'h0000_0000, 32'h0000_0000, 32'h0000_0016, 32'h0000_0000, 32'h0000_0000);
    run(10);
    check("spread off", 32'(spreadActive), 32'h0000_0000);
    check("feedback 2N", 32'(feedbackValue), 32'h0000_0B00);
    axi_write(spread_pkg::NOMINAL_OFS, 32'h0003_0016, spread_pkg::RESP_OKAY);
    run(10);
    axi_read(spread_pkg::STATUS_OFS, 32'h0000_0C00, spread_pkg::RESP_OKAY);
    $display("test nominal done");
    // legal host setup: deltas 1 and 2, unused samples set to 8.
    cfg(32'h0000_0011, 32'h0000_0004, 32'h0003_0016, 32'h8888_8821, 32'h0000_8888);
    fbGapExp = 3;
    run(300);
    check("spread on", 32'(spreadActive), 32'h0000_0001);
    check("step gap", 32'(fbBad), 32'h0000_0000);
    check("steps seen", 32'(fbChg > 8), 32'h0000_0001);
    check("profile max", 32'(fbMax), 32'h0000_0C07);
    check("profile min", 32'(fbMin), 32'h0000_0C01);
    $display("test profile done");
    // double set by host; slow detector.
    pfdGap <= 4'h7;
    axi_write(spread_pkg::CTRL_OFS, 32'h0000_0211, spread_pkg::RESP_OKAY);
    run(500);
    check("double max", 32'(fbMax), 32'h0000_0C0A);
    check("double min", 32'(fbMin), 32'h0000_0BFE);
    check("slow gap", 32'(fbBad), 32'h0000_0000);
    $display("test double done");
    pfdGap <= 4'h2;
    fbGapExp = 5;
    axi_write(spread_pkg::SAMPLES_LO_OFS, 32'h8888_1111, spread_pkg::RESP_OKAY);
    axi_write(spread_pkg::CTRL_OFS, 32'h0000_0023, spread_pkg::RESP_OKAY);
    run(400);
    check("quad gap", 32'(fbBad), 32'h0000_0000);
    check("quad max", 32'(fbMax), 32'h0000_0C08);
    check("quad min", 32'(fbMin), 32'h0000_0C00);
    $display("test quadrant done");
    cfg(32'h0000_0111, 32'h0000_0004, 32'h0003_0016, 32'h0000_0000, 32'h0000_0000);
    run(300);
    check("dither low", 32'(fbMin), 32'h0000_0C04);
    check("dither high", 32'(fbMax), 32'h0000_0C05);
    $display("test dither done");
    axi_write(spread_pkg::CTRL_OFS, 32'h0000_0000, spread_pkg::RESP_OKAY);
    phGapExp = 4;
    lpGapExp = 5;
    run(200);
    check("pll3 idle phase", 32'(phChg), 32'h0000_0000);
    check("pll3 idle loop", 32'(lpChg), 32'h0000_0000);
    axi_write(spread_pkg::CTRL_OFS, 32'h0000_1000, spread_pkg::RESP_OKAY);
    run(300);
    check("pll3 phases", 32'(phChg > 5), 32'h0000_0001);
    check("pll3 phase gap", 32'(phBad), 32'h0000_0000);
    check("pll3 loops", 32'(lpChg > 5), 32'h0000_0001);
    check("pll3 loop gap", 32'(lpBad), 32'h0000_0000);
    $display("test pll3 done");
    final_report();
  end
endmodule : test_spread_spectrum_modulator
